//--- hw/psel_pkg.sv
// Package: register map, reset values and carrier types of the event latch block
`default_nettype none
package psel_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RISE_WR = 8'h0d;
    localparam logic [7:0] IDX_RISE_CLR = 8'h0f;
    localparam logic [7:0] IDX_FALL_WR = 8'h10;
    localparam logic [7:0] IDX_FALL_CLR = 8'h12;
    localparam logic [7:0] IDX_LIVE_STATUS = 8'h13;
    localparam logic [7:0] IDX_STICKY_FLAGS = 8'h14;
    localparam logic [7:0] IDX_LINE_DEBUG = 8'h15;
    localparam logic [7:0] IDX_SPARE_WR = 8'h16;
    localparam logic [7:0] IDX_SPARE_CLR = 8'h18;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h22;

    // Alias kinds relative to the first alias of a set/clear group
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_SET = 2'h1;
    localparam logic [1:0] ALIAS_CLEAR = 2'h2;

    // Field positions
    localparam int SRC_WIDTH = 5;
    localparam int HOST_DISC_BIT = 0;
    localparam int BUS_VALID_BIT = 1;
    localparam int SESS_OK_BIT = 2;
    localparam int SESS_ENDED_BIT = 3;
    localparam int MODE_HOST_BIT = 0;

    // Values after reset
    localparam logic [4:0] RISE_EN_RESET = 5'h1f;
    localparam logic [4:0] FALL_EN_RESET = 5'h1f;
    localparam logic [7:0] SPARE_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam logic MODE_HOST_RESET = 1'b0;

    // Five monitored sources, bit 4 first
    typedef struct packed {
        logic id_pin_grounded;
        logic session_power_ended;
        logic session_power_ok;
        logic bus_power_valid;
        logic host_disconnect;
    } psel_src_t;

    // Access phase of an APB request as seen by the register file
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } psel_req_t;
endpackage : psel_pkg
`default_nettype wire

//--- hw/psel_top.sv
// Event latch: source sync, edge detect, alias registers and APB slave
//
// Overview of operation
// [RULE1] Falling enable byte readable at three aliases: write, set, clear.
// [RULE2] Set alias ORs data in; clear alias clears bits written as one.
// [RULE3] Falling enable bits per source, default one, arm high-to-low edges.
// [RULE4] Downstream detach events only produced while in host mode.
// [RULE5] Rising enable byte, same layout, default ones, arms low-to-high edges.
// [RULE6] Live status byte shows present source levels; writes ignored.
// [RULE7] Status bits 0-4 are the five sources; bits 7-5 read zero.
// [RULE8] Bus-power status reads zero when both its enables are set.
// [RULE9] Session-end status reads zero when both its enables are set.
// [RULE10] Session-valid status always shows the live level.
// [RULE11] Status zero only after reset; reads return present levels.
// [RULE12] Armed transition on a source sets its latch bit.
// [RULE13] Latch read returns contents then clears; not writable; bits 7-5 zero.
// [RULE14] Event in the same cycle as latch read clear stays set.
// [RULE15] Debug byte shows line-level pair in bits 1-0, zeros above.
// [RULE16] Scratch byte read/write/set/clear, reset zero, no side effects.
// [RULE17] Edges found by comparing synchronized level with previous cycle.
//
// Sources and line levels are asynchronous and pass two flops first.
// A pin change reaches live status two edges later, the flags three.
// Clear-on-read drops only what the read returned, so a late event survives.
// Host mode gates detach events but not the live detach level.
// Limitation: inputs already high at reset release look like rising edges.
`default_nettype none
module psel_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire psel_pkg::psel_src_t src_pins,
    input wire logic [1:0] line_state_pins,
    output logic irq
);
    // Two-flop synchronisers; stage one is read only by stage two
    psel_pkg::psel_src_t src_s1_q;
    psel_pkg::psel_src_t src_s2_q;
    psel_pkg::psel_src_t src_prev_q;
    logic [1:0] line_s1_q;
    logic [1:0] line_s2_q;

    // Register state
    logic [4:0] rise_en_q;
    logic [4:0] rise_en_d;
    logic [4:0] fall_en_q;
    logic [4:0] fall_en_d;
    logic [7:0] spare_q;
    logic [7:0] spare_d;
    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [4:0] irq_stat_q;
    logic [4:0] irq_stat_d;
    logic [4:0] irq_mask_q;
    logic [4:0] irq_mask_d;
    logic host_mode_q;
    logic host_mode_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // Bus decode
    psel_pkg::psel_req_t req;
    logic setup_phase;
    logic access_phase;
    logic addr_aligned;
    logic hit_rise;
    logic hit_fall;
    logic hit_live;
    logic hit_flags;
    logic hit_debug;
    logic hit_spare;
    logic hit_irq_stat;
    logic hit_irq_mask;
    logic hit_mode;
    logic mapped;
    logic [1:0] rise_kind;
    logic [1:0] fall_kind;
    logic [1:0] spare_kind;
    logic [7:0] rd_value;
    logic rd_capture;

    // Per-register strobes, one access edge each
    logic we_rise;
    logic we_fall;
    logic we_spare;
    logic we_irq_stat;
    logic we_irq_mask;
    logic we_mode;
    logic re_flags;

    // Read words, each zero-extended to a byte
    logic [7:0] rdw_rise;
    logic [7:0] rdw_fall;
    logic [7:0] rdw_live;
    logic [7:0] rdw_flags;
    logic [7:0] rdw_debug;
    logic [7:0] rdw_irq_stat;
    logic [7:0] rdw_irq_mask;
    logic [7:0] rdw_mode;

    // Event path
    logic [4:0] src_now;
    logic [4:0] src_old;
    logic [4:0] rose;
    logic [4:0] fell;
    logic [4:0] host_gate;
    logic [4:0] events;
    logic [4:0] live_status;
    logic [4:0] flags_taken;
    logic [4:0] both_en;
    logic [4:0] irq_clear;
    logic [4:0] irq_pending;

    // Write, set or clear through an alias group
    function automatic logic [7:0] alias_upd(
        input logic [7:0] cur,
        input logic [7:0] wd,
        input logic [1:0] kind
    );
        logic [7:0] res;
        res = cur;
        case (kind)
            psel_pkg::ALIAS_WRITE: res = wd;
            psel_pkg::ALIAS_SET: res = cur | wd;
            psel_pkg::ALIAS_CLEAR: res = cur & ~wd;
            default: res = cur;
        endcase
        return res;
    endfunction : alias_upd

    // Stage one of each synchroniser; may go metastable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1_q <= '0;
            line_s1_q <= 2'h0;
        end else begin
            src_s1_q <= src_pins;
            line_s1_q <= line_state_pins;
        end
    end

    // Stage two, the only reader of stage one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s2_q <= '0;
            line_s2_q <= 2'h0;
        end else begin
            src_s2_q <= src_s1_q;
            line_s2_q <= line_s1_q;
        end
    end

    // [RULE17] Previous synchronized level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_q <= '0;
        end else begin
            src_prev_q <= src_s2_q;
        end
    end

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign req.idx = paddr[9:2];
    assign req.wdata = pwdata[7:0];
    assign req.wr = access_phase & pwrite;
    assign req.rd = access_phase & ~pwrite;

    // Writes and read side effects act only on the access edge
    assign we_rise = req.wr & hit_rise;
    assign we_fall = req.wr & hit_fall;
    assign we_spare = req.wr & hit_spare;
    assign we_irq_stat = req.wr & hit_irq_stat;
    assign we_irq_mask = req.wr & hit_irq_mask;
    assign we_mode = req.wr & hit_mode;
    assign re_flags = req.rd & hit_flags;

    // [RULE1] Three-alias groups
    assign hit_rise = addr_aligned && req.idx >= psel_pkg::IDX_RISE_WR
        && req.idx <= psel_pkg::IDX_RISE_CLR;
    assign hit_fall = addr_aligned && req.idx >= psel_pkg::IDX_FALL_WR
        && req.idx <= psel_pkg::IDX_FALL_CLR;
    assign hit_spare = addr_aligned && req.idx >= psel_pkg::IDX_SPARE_WR
        && req.idx <= psel_pkg::IDX_SPARE_CLR;
    assign hit_live = addr_aligned && req.idx == psel_pkg::IDX_LIVE_STATUS;
    assign hit_flags = addr_aligned && req.idx == psel_pkg::IDX_STICKY_FLAGS;
    assign hit_debug = addr_aligned && req.idx == psel_pkg::IDX_LINE_DEBUG;
    assign hit_irq_stat = addr_aligned && req.idx == psel_pkg::IDX_IRQ_STATUS;
    assign hit_irq_mask = addr_aligned && req.idx == psel_pkg::IDX_IRQ_MASK;
    assign hit_mode = addr_aligned && req.idx == psel_pkg::IDX_MODE_CTRL;
    assign mapped = hit_rise | hit_fall | hit_spare | hit_live | hit_flags | hit_debug
        | hit_irq_stat | hit_irq_mask | hit_mode;

    assign rise_kind = 2'(req.idx - psel_pkg::IDX_RISE_WR);
    assign fall_kind = 2'(req.idx - psel_pkg::IDX_FALL_WR);
    assign spare_kind = 2'(req.idx - psel_pkg::IDX_SPARE_WR);

    // [RULE17] Compare with previous synchronized level
    assign src_now = src_s2_q;
    assign src_old = src_prev_q;

    // One slice per source; only detach and the two maskable bits differ
    for (genvar i = 0; i < psel_pkg::SRC_WIDTH; i++) begin : g_src
        localparam logic IS_DETACH = (i == psel_pkg::HOST_DISC_BIT);
        localparam logic MASKABLE = (i == psel_pkg::BUS_VALID_BIT)
            || (i == psel_pkg::SESS_ENDED_BIT);
        // [RULE17] One-cycle edge pulses
        assign rose[i] = src_now[i] & ~src_old[i];
        assign fell[i] = ~src_now[i] & src_old[i];
        // [RULE4] Detach events need host mode
        assign host_gate[i] = IS_DETACH ? host_mode_q : 1'b1;
        // [RULE5] Rising and [RULE3] falling enables arm each source
        assign events[i] = ((rose[i] & rise_en_q[i]) | (fell[i] & fall_en_q[i]))
            & host_gate[i];
        // [RULE8] Bus power and [RULE9] session end hide when both armed
        // [RULE10] Session valid is never masked
        assign both_en[i] = rise_en_q[i] & fall_en_q[i];
        // [RULE6] Live levels, not a snapshot
        // [RULE11] Zero only while synchronisers hold reset value
        assign live_status[i] = src_now[i] & ~(MASKABLE & both_en[i]);
    end

    // [RULE7] Upper bits of narrow registers read zero
    assign rdw_rise = {3'h0, rise_en_q};
    assign rdw_fall = {3'h0, fall_en_q};
    assign rdw_live = {3'h0, live_status};
    // [RULE13] Latch bits 7-5 read zero
    assign rdw_flags = {3'h0, flags_q};
    // [RULE15] Line-level pair in bits 1-0
    assign rdw_debug = {6'h00, line_s2_q};
    assign rdw_irq_stat = {3'h0, irq_stat_q};
    assign rdw_irq_mask = {3'h0, irq_mask_q};
    assign rdw_mode = {7'h00, host_mode_q};

    // Unmapped addresses fall through to zero
    assign rd_value = hit_rise ? rdw_rise
        : hit_fall ? rdw_fall
        : hit_live ? rdw_live
        : hit_flags ? rdw_flags
        : hit_debug ? rdw_debug
        : hit_spare ? spare_q
        : hit_irq_stat ? rdw_irq_stat
        : hit_irq_mask ? rdw_irq_mask
        : hit_mode ? rdw_mode
        : 8'h00;

    // Read data is captured in setup so prdata comes from a flop
    // Costs no wait state: the access edge already sees the stored byte
    assign rd_capture = setup_phase & ~pwrite;
    assign prdata_d = rd_capture ? {24'h000000, rd_value} : prdata_q;

    // [RULE2] Set ORs in, clear removes ones
    assign rise_en_d = we_rise
        ? 5'(alias_upd(rdw_rise, req.wdata, rise_kind)) : rise_en_q;
    assign fall_en_d = we_fall
        ? 5'(alias_upd(rdw_fall, req.wdata, fall_kind)) : fall_en_q;
    // [RULE16] Scratch has no other effect
    assign spare_d = we_spare ? alias_upd(spare_q, req.wdata, spare_kind) : spare_q;

    // Clear only what the read returned; later arrivals survive
    assign flags_taken = re_flags ? prdata_q[4:0] : 5'h00;
    // [RULE12] Armed edges set latch bits
    // [RULE13] Read clears, writes ignored
    // [RULE14] New event wins over clear
    assign flags_d = (flags_q & ~flags_taken) | events;

    // Set wins over write-one-to-clear
    assign irq_clear = we_irq_stat ? req.wdata[4:0] : 5'h00;
    assign irq_stat_d = (irq_stat_q & ~irq_clear) | events;
    assign irq_mask_d = we_irq_mask ? req.wdata[4:0] : irq_mask_q;
    assign host_mode_d = we_mode ? req.wdata[psel_pkg::MODE_HOST_BIT] : host_mode_q;

    // [RULE5] Rising enables default to ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_en_q <= psel_pkg::RISE_EN_RESET;
        end else begin
            rise_en_q <= rise_en_d;
        end
    end

    // [RULE3] Falling enables default to ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_en_q <= psel_pkg::FALL_EN_RESET;
        end else begin
            fall_en_q <= fall_en_d;
        end
    end

    // [RULE16] Scratch resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spare_q <= psel_pkg::SPARE_RESET;
        end else begin
            spare_q <= spare_d;
        end
    end

    // [RULE12] Sticky flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= psel_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Interrupt status shares the flag events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= psel_pkg::FLAGS_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Mask starts closed so reset-time edges raise no interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= psel_pkg::IRQ_MASK_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // [RULE4] Host mode starts off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_mode_q <= psel_pkg::MODE_HOST_RESET;
        end else begin
            host_mode_q <= host_mode_d;
        end
    end

    // Read data register; holds until the next read setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;
    assign prdata = prdata_q;
    // Level interrupt: any unmasked sticky status bit
    assign irq_pending = irq_stat_q & irq_mask_q;
    assign irq = |irq_pending;
endmodule : psel_top
`default_nettype wire

//--- sim/psel_top_chk.sv
// Checker: APB answer and live status properties of the event latch
`default_nettype none
module psel_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire psel_pkg::psel_src_t src_pins,
    input wire logic [1:0] line_state_pins,
    input wire logic irq
);
    // Sources must sit still past both sync stages before a read means anything
    logic [1:0] stab_q;
    logic [1:0] stab_d;
    psel_pkg::psel_src_t prev_q;
    logic same;
    assign same = (src_pins == prev_q);
    assign stab_d = !same ? 2'h0 : (stab_q == 2'h3) ? stab_q : stab_q + 2'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_q <= 2'h0;
            prev_q <= '0;
        end else begin
            stab_q <= stab_d;
            prev_q <= src_pins;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_ready; s_access |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_unmapped; s_access ##0 paddr == 12'h0fc |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    property p_alias_ok; s_access ##0 paddr inside {12'h040, 12'h044, 12'h048} |-> !pslverr; endproperty
    a_alias_ok: assert property (p_alias_ok) else $error("alias refused");
    property p_status_hi; s_rd_setup(12'h04c) |=> prdata[31:5] == '0; endproperty
    a_status_hi: assert property (p_status_hi) else $error("status high bits");
    property p_flags_hi; s_rd_setup(12'h050) |=> prdata[31:5] == '0; endproperty
    a_flags_hi: assert property (p_flags_hi) else $error("flags high bits");
    property p_debug_hi; s_rd_setup(12'h054) |=> prdata[31:2] == '0; endproperty
    a_debug_hi: assert property (p_debug_hi) else $error("debug high bits");
    property p_live; s_rd_setup(12'h04c) ##0 (same && stab_q >= 2'h2) |=>
        prdata[2] == $past(src_pins.session_power_ok) && prdata[4] == $past(src_pins.id_pin_grounded);
    endproperty
    a_live: assert property (p_live) else $error("status not live");
    property p_reset_zero; $rose(presetn) |-> prdata == '0 && !irq; endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear");
endmodule : psel_top_chk
bind psel_top psel_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_pins(src_pins),
    .line_state_pins(line_state_pins), .irq(irq));
`default_nettype wire

//--- sim/psel_apb_model.sv
// Link-side model: APB master for register accesses
`default_nettype none
module psel_apb_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // each alias is its own word
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
        output logic [7:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : psel_apb_model
`default_nettype wire

//--- sim/testbench.sv
// Testbench: aliases, live status, sticky flags and interrupt
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rv;
    psel_pkg::psel_src_t src_pins = '0;
    logic [1:0] line_state_pins = 2'h0;
    int fails = 0;
    int compares = 0;
    always #12.5 pclk = ~pclk;
    psel_apb_model link (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    psel_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_pins(src_pins), .line_state_pins(line_state_pins), .irq(irq));
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        link.xfer(1'b1, idx, d, rv, ev);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        link.xfer(1'b0, idx, 8'h00, rv, ev);
        chk($sformatf("reg %h", idx), rv, exp);
    endtask : rd
    // Four edges cover both sync stages and the flag update
    task automatic pins(input psel_pkg::psel_src_t s);
        @(posedge pclk);
        src_pins <= s;
        repeat (4) @(posedge pclk);
    endtask : pins
    task automatic irq_is(input logic exp);
        @(negedge pclk);
        chk("irq", {7'h0, irq}, {7'h0, exp});
    endtask : irq_is
    task automatic t_defaults;
        for (int i = 0; i < 3; i++) begin
            rd(8'h0d + i[7:0], psel_pkg::RISE_EN_RESET);
            rd(8'h10 + i[7:0], psel_pkg::FALL_EN_RESET);
            rd(8'h16 + i[7:0], psel_pkg::SPARE_RESET);
        end
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
    endtask : t_defaults
    task automatic t_alias;
        logic [7:0] b, m;
        for (int g = 0; g < 3; g++) begin
            b = (g == 0) ? 8'h0d : (g == 1) ? 8'h10 : 8'h16;
            m = (g == 2) ? 8'hff : 8'h1f;
            wr(b, 8'ha5);
            rd(b + 8'h1, 8'ha5 & m);
            wr(b + 8'h1, 8'h0a);
            rd(b + 8'h2, 8'haf & m);
            wr(b + 8'h2, 8'h21);
            rd(b, 8'h8e & m);
            wr(b, 8'h1f);
        end
    endtask : t_alias
    task automatic t_status;
        pins(5'h1f);
        rd(8'h13, 8'h15);
        wr(8'h13, 8'h00);
        wr(8'h12, 8'h0a);
        rd(8'h13, 8'h1f);
        wr(8'h11, 8'h0a);
        pins(5'h00);
        rd(8'h13, 8'h00);
    endtask : t_status
    task automatic t_events;
        rd(8'h14, 8'h1e);
        rd(8'h14, 8'h00);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h00);
        wr(8'h22, 8'h01);
        pins(5'h11);
        rd(8'h14, 8'h11);
        wr(8'h12, 8'h10);
        wr(8'h0f, 8'h10);
        pins(5'h01);
        rd(8'h14, 8'h00);
        wr(8'h22, 8'h00);
        pins(5'h00);
        rd(8'h14, 8'h00);
    endtask : t_events
    task automatic t_irq;
        irq_is(1'b0);
        wr(8'h21, 8'h01);
        irq_is(1'b1);
        wr(8'h20, 8'h1f);
        irq_is(1'b0);
    endtask : t_irq
    // Event on the clearing edge must survive the read
    task automatic t_race;
        pins(5'h04);
        @(posedge pclk);
        src_pins <= 5'h00;
        link.xfer(1'b0, 8'h14, 8'h00, rv, ev);
        chk("flags before race", rv, 8'h04);
        rd(8'h14, 8'h04);
        rd(8'h14, 8'h00);
    endtask : t_race
    task automatic t_debug_err;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            line_state_pins <= i[1:0];
            repeat (3) @(posedge pclk);
            rd(8'h15, {6'h0, i[1:0]});
        end
        link.xfer(1'b0, 8'h3f, 8'h00, rv, ev);
        chk("unmapped error", {7'h0, ev}, 8'h01);
        chk("unmapped data", rv, 8'h00);
    endtask : t_debug_err
    task automatic final_report;
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_alias();
        t_status();
        t_events();
        t_irq();
        t_race();
        t_debug_err();
        final_report();
    end
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
